// ---- dv/flag_board_model.sv ----
// board around one lone device: straps, master reset pin and token loopback
// assumes the bench requests a master reset by holding mreset_req high for several cycles
`timescale 1ns/1ps
`default_nettype none
module flag_board_model (
    // clock and bench requests
    input wire logic ref_clk,
    input wire logic mreset_req,
    input wire logic polled_req,
    // ring tokens leaving the device
    input wire logic full_token_out,
    input wire logic empty_token_out,
    // pins into the device
    output logic master_reset_n,
    output logic flag_mode_strap,
    output logic master_select_strap,
    output logic full_token_in,
    output logic empty_token_in
);
    // the only device on the board, so it alone is master
    assign master_select_strap = 1'b1;
    // lone device: each token output wired straight back to its own input
    assign full_token_in = full_token_out;
    assign empty_token_in = empty_token_out;
    // reset pin follows the request one edge late, like a board pulse
    always_ff @(posedge ref_clk) begin
        master_reset_n <= ~mreset_req;
    end
    // strap only moves while master reset is held, never in operation
    always_ff @(posedge ref_clk) begin
        if (mreset_req) begin
            flag_mode_strap <= polled_req;
        end
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the shared queue flag status buses
// assumes a single master device on the board model, registers on the plain strobe port
`timescale 1ns/1ps
`default_nettype none
module testbench
    import qflag_pkg::*;
;
    localparam logic [ID_W-1:0] DEV_ID = 3'h5;
    localparam logic [31:0] AF = 32'h1E2D3C4B;
    localparam logic [31:0] AE = 32'h5A697887;
    localparam logic [31:0] PKT = 32'h96A5B4C3;
    localparam logic [31:0] VLD = 32'hD2E1F00F;
    localparam int CYC_LIMIT = 3000;
    // stimulus
    logic ref_clk, reset, mreset_req, polled_req, read_queue_select, empty_quadrant_strobe;
    logic reg_write, reg_read;
    logic [RADDR_W-1:0] read_queue_address;
    logic [REG_AW-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [ID_W-1:0] device_id_strap;
    queue_flags_s queue_flags;
    // pins between board and device
    logic master_reset_n, flag_mode_strap, master_select_strap, full_token_in, empty_token_in;
    logic full_token_out, empty_token_out;
    // observed outputs
    logic output_valid_n, almost_empty_n, packet_ready_n;
    bus_drive_s af_bus, ae_bus;
    logic [31:0] reg_rdata;
    int n_mismatch, cmp_count, cyc_count;

    flag_board_model board (
        .ref_clk(ref_clk), .mreset_req(mreset_req), .polled_req(polled_req),
        .full_token_out(full_token_out), .empty_token_out(empty_token_out),
        .master_reset_n(master_reset_n), .flag_mode_strap(flag_mode_strap),
        .master_select_strap(master_select_strap), .full_token_in(full_token_in),
        .empty_token_in(empty_token_in)
    );

    queue_flag_status_bus dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .master_reset_n(master_reset_n),
        .flag_mode_strap(flag_mode_strap), .master_select_strap(master_select_strap),
        .device_id_strap(device_id_strap), .full_token_in(full_token_in),
        .empty_token_in(empty_token_in), .full_token_out(full_token_out),
        .empty_token_out(empty_token_out), .queue_flags(queue_flags),
        .read_queue_address(read_queue_address), .read_queue_select(read_queue_select),
        .empty_quadrant_strobe(empty_quadrant_strobe), .output_valid_n(output_valid_n),
        .almost_empty_n(almost_empty_n), .packet_ready_n(packet_ready_n),
        .almost_full_status_bus(af_bus), .almost_empty_packet_status_bus(ae_bus),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata)
    );

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // a hang counts as a mismatch and closes the run
    always @(posedge ref_clk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == CYC_LIMIT) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // one-cycle write strobe
    task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [REG_AW-1:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        chk_word(reg_rdata & m, exp);
    endtask

    // master reset pulse, strap picks the flag mode
    task automatic dev_reset(input logic polled);
        @(posedge ref_clk);
        polled_req <= polled;
        mreset_req <= 1'b1;
        repeat (6) @(posedge ref_clk);
        mreset_req <= 1'b0;
    endtask

    function automatic bus_drive_s pick(input logic which);
        return which ? ae_bus : af_bus;
    endfunction

    // follows one ownership of a polled bus, then the loopback return
    task automatic poll_check(input logic which, input logic [31:0] v);
        bus_drive_s b;
        int n;
        b = pick(which);
        n = 0;
        while (b.sync_mark !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1;
            b = pick(which);
            n++;
        end
        for (int q = 0; q < NUM_QUADS; q++) begin
            chk_word(32'(b.data), 32'(v[q*8 +: 8]));
            chk_bit(b.sync_mark, q == 0);
            chk_bit(b.oe_n, 1'b0);
            @(posedge ref_clk);
            #1;
            b = pick(which);
        end
        // bus let go and token handed on in the same cycle
        chk_bit(b.oe_n, 1'b1);
        chk_bit(which ? empty_token_out : full_token_out, 1'b1);
        repeat (3) @(posedge ref_clk);
        #1;
        b = pick(which);
        chk_bit(b.sync_mark, 1'b1);
    endtask

    // small configuration: fixed lines, never a sync mark
    task automatic small_check(input logic [7:0] exp);
        repeat (4) begin
            @(posedge ref_clk);
            #1;
            chk_word(32'(ae_bus.data), 32'(exp));
            chk_bit(ae_bus.oe_n | ae_bus.sync_mark, 1'b0);
        end
    endtask

    initial begin
        reset = 1'b1;
        mreset_req = 1'b1;
        polled_req = 1'b1;
        read_queue_select = 1'b0;
        empty_quadrant_strobe = 1'b0;
        read_queue_address = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        device_id_strap = DEV_ID;
        queue_flags = {AF, AE, PKT, VLD};
        n_mismatch = 0;
        cmp_count = 0;
        cyc_count = 0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        reg_rd(CTRL_OFS, 32'(QCNT_RST), 32'h0000013F);
        // polled mode, lone master
        dev_reset(1'b1);
        poll_check(1'b0, AF);
        poll_check(1'b1, AE);
        reg_rd(STATUS_OFS, 32'h00000003, 32'h00000003);
        reg_rd(4'hC, 32'h0, 32'hFFFFFFFF);
        // direct mode: full bus floats, quadrants back to back
        dev_reset(1'b0);
        repeat (4) @(posedge ref_clk);
        #1;
        chk_bit(af_bus.oe_n, 1'b1);
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            empty_quadrant_strobe <= (i < 4);
            read_queue_address <= {DEV_ID, 3'h0, 2'(i)};
            #1;
            if (i >= 2) begin
                chk_word(32'(ae_bus.data), 32'(AE[(i-2)*8 +: 8]));
                chk_bit(ae_bus.oe_n, 1'b0);
            end
        end
        // strobe beside a read queue select is refused
        @(posedge ref_clk);
        read_queue_select <= 1'b1;
        empty_quadrant_strobe <= 1'b1;
        read_queue_address <= {DEV_ID, 5'h09};
        @(posedge ref_clk);
        read_queue_select <= 1'b0;
        empty_quadrant_strobe <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk_word(32'(ae_bus.data), 32'(AE[31:24]));
        chk_bit(output_valid_n, VLD[9]);
        chk_bit(almost_empty_n, AE[9]);
        chk_bit(packet_ready_n, PKT[9]);
        // another device id: bus floats
        @(posedge ref_clk);
        empty_quadrant_strobe <= 1'b1;
        read_queue_address <= {~DEV_ID, 5'h01};
        @(posedge ref_clk);
        empty_quadrant_strobe <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk_bit(ae_bus.oe_n, 1'b1);
        // read-only and unmapped writes leave no trace
        reg_wr(STATUS_OFS, 32'hFFFFFFFF);
        reg_rd(STATUS_OFS, 32'h00000002, 32'h000000FF);
        reg_wr(4'hC, 32'hFFFFFFFF);
        reg_rd(4'hC, 32'h0, 32'hFFFFFFFF);
        // eight queues, packet ready then almost empty
        reg_wr(CTRL_OFS, 32'h00000108);
        reg_rd(CTRL_OFS, 32'h00000108, 32'h0000013F);
        small_check(PKT[7:0]);
        reg_wr(CTRL_OFS, 32'h00000008);
        @(posedge ref_clk);
        small_check(AE[7:0]);
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- verilog/poll_ring_seq.sv ----
// token ring sequencer for one polled flag bus: owns the bus for four quadrants
// assumes start and token_rise are one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module poll_ring_seq
    import qflag_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // control
    input wire logic polled,
    input wire logic start,
    input wire logic token_rise,
    // state and its next value
    output logic own_ff,
    output logic [QUAD_W-1:0] quad_ff,
    output logic nxt_own,
    output logic [QUAD_W-1:0] nxt_quad,
    output logic token_out_ff
);
    // next ownership and quadrant
    always_comb begin
        nxt_own = own_ff;
        nxt_quad = quad_ff;
        if (!polled) begin
            nxt_own = 1'b0;
            nxt_quad = QUAD_FIRST;
        end else if (start || token_rise) begin
            // a fresh token always restarts at the first quadrant
            nxt_own = 1'b1;
            nxt_quad = QUAD_FIRST;
        end else if (own_ff) begin
            if (quad_ff == QUAD_LAST) begin
                nxt_own = 1'b0;
                nxt_quad = QUAD_FIRST;
            end else begin
                nxt_quad = quad_ff + 2'h1;
            end
        end
    end

    // ownership state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            own_ff <= 1'b0;
            quad_ff <= QUAD_FIRST;
        end else if (clk_en) begin
            own_ff <= nxt_own;
            quad_ff <= nxt_quad;
        end
    end

    // token leaves as a pulse during the last owned quadrant's successor edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            token_out_ff <= 1'b0;
        end else if (clk_en) begin
            token_out_ff <= polled && own_ff && (quad_ff == QUAD_LAST);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/qflag_pkg.sv ----
// package for the queue flag status buses: sizes, reset values, register map
// assumes one clock domain; every pin arrives asynchronously and is synchronised in the top
package qflag_pkg;
    // queue and bus geometry
    localparam int NUM_QUEUES = 32;
    localparam int BUS_W = 8;
    localparam int NUM_QUADS = 4;
    localparam int QUAD_W = 2;
    localparam int QCNT_W = 6;
    localparam int ID_W = 3;
    localparam int RADDR_W = ID_W + 5;
    localparam logic [QUAD_W-1:0] QUAD_FIRST = 2'h0;
    localparam logic [QUAD_W-1:0] QUAD_LAST = 2'h3;
    // largest queue count that still gives each queue its own bus line
    localparam logic [QCNT_W-1:0] QCNT_DEDICATED = 6'h08;
    // register bus geometry and offsets
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] CTRL_OFS = 4'h0;
    localparam logic [REG_AW-1:0] STATUS_OFS = 4'h4;
    // control field positions
    localparam int CTRL_QCNT_LSB = 0;
    localparam int CTRL_PKT_BIT = 8;
    // status field positions
    localparam int ST_POLLED_BIT = 0;
    localparam int ST_MASTER_BIT = 1;
    localparam int ST_FOWN_BIT = 2;
    localparam int ST_EOWN_BIT = 3;
    localparam int ST_EQUAD_LSB = 4;
    localparam int ST_FQUAD_LSB = 6;
    // values after reset
    localparam logic [QCNT_W-1:0] QCNT_RST = 6'h20;
    localparam logic PKT_RST = 1'b0;
    localparam logic [BUS_W-1:0] BUS_RST = 8'hFF;
    localparam int SYNC_STAGES = 2;

    // per-queue flag vectors from the queue core, all active low
    typedef struct packed {
        logic [NUM_QUEUES-1:0] almost_full_n;
        logic [NUM_QUEUES-1:0] almost_empty_n;
        logic [NUM_QUEUES-1:0] packet_ready_n;
        logic [NUM_QUEUES-1:0] output_valid_n;
    } queue_flags_s;

    // one shared bus drive: data plus active-low enable and first-quadrant sync mark
    typedef struct packed {
        logic [BUS_W-1:0] data;
        logic oe_n;
        logic sync_mark;
    } bus_drive_s;
endpackage

// ---- verilog/quad_select.sv ----
// eight-line slice of a 32-queue flag vector picked by quadrant number
// assumes the caller registers the result before it reaches a pin
`timescale 1ns/1ps
`default_nettype none
module quad_select
    import qflag_pkg::*;
(
    // source and selection
    input wire logic [NUM_QUEUES-1:0] flags_n,
    input wire logic [QUAD_W-1:0] quad,
    // selected slice
    output logic [BUS_W-1:0] slice_n
);
    // line k carries queue quad*8+k
    genvar k;
    generate
        for (k = 0; k < BUS_W; k++) begin : g_line
            assign slice_n[k] = flags_n[{quad, 3'(k)}];
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verilog/queue_flag_status_bus.sv ----
// shared almost-full and almost-empty/packet-ready status buses of a 32-queue device
// assumes straps, tokens and master reset are pins; queue flags and selects come from core logic
`timescale 1ns/1ps
`default_nettype none
module queue_flag_status_bus
    import qflag_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // device pins: straps, master reset, ring tokens
    input wire logic master_reset_n,
    input wire logic flag_mode_strap,
    input wire logic master_select_strap,
    input wire logic [ID_W-1:0] device_id_strap,
    input wire logic full_token_in,
    input wire logic empty_token_in,
    output logic full_token_out,
    output logic empty_token_out,
    // queue core flags and read-port selection
    input wire queue_flags_s queue_flags,
    input wire logic [RADDR_W-1:0] read_queue_address,
    input wire logic read_queue_select,
    input wire logic empty_quadrant_strobe,
    // dedicated read-port flags
    output logic output_valid_n,
    output logic almost_empty_n,
    output logic packet_ready_n,
    // shared status buses
    output bus_drive_s almost_full_status_bus,
    output bus_drive_s almost_empty_packet_status_bus,
    // register port
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata
);
    localparam int PIN_W = 5 + ID_W;

    // pin synchroniser stages; first stage feeds only the second
    logic [PIN_W-1:0] pin_meta_ff;
    logic [PIN_W-1:0] pin_sync_ff;
    logic mr_prev_ff; // master reset level one cycle back
    logic ftok_prev_ff; // full token level one cycle back
    logic etok_prev_ff; // empty token level one cycle back
    logic polled_ff; // latched flag mode
    logic master_ff; // latched master strap
    logic [QCNT_W-1:0] qcount_ff; // configured queue count
    logic pkt_mode_ff; // bus carries packet ready when set
    logic [QUAD_W-1:0] dir_quad_ff; // direct mode quadrant
    logic dir_match_ff; // last selection addressed this device
    logic [4:0] rd_queue_ff; // queue selected for reading
    logic mr_n_s, mode_s, master_s, ftok_s, etok_s;
    logic [ID_W-1:0] id_s;
    logic seq_rst, release_pulse, ftok_rise, etok_rise, small_cfg;
    logic f_own, e_own, f_nxt_own, e_nxt_own;
    logic [QUAD_W-1:0] f_quad, e_quad, f_nxt_quad, e_nxt_quad;
    logic [NUM_QUEUES-1:0] empty_src_n;
    logic [BUS_W-1:0] f_slice, e_poll_slice, e_dir_slice;

    assign {mr_n_s, mode_s, master_s, ftok_s, etok_s, id_s} = pin_sync_ff;

    // two-stage synchroniser for every pin input
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else if (clk_en) begin
            pin_meta_ff <= {master_reset_n, flag_mode_strap, master_select_strap,
                            full_token_in, empty_token_in, device_id_strap};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // previous levels for release and token edge detection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mr_prev_ff <= 1'b0;
            ftok_prev_ff <= 1'b0;
            etok_prev_ff <= 1'b0;
        end else if (clk_en) begin
            mr_prev_ff <= mr_n_s;
            ftok_prev_ff <= ftok_s;
            etok_prev_ff <= etok_s;
        end
    end

    // mode and master straps are caught while master reset is low, frozen once it rises
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            polled_ff <= 1'b0;
            master_ff <= 1'b0;
        end else if (clk_en && !mr_n_s) begin
            polled_ff <= mode_s;
            master_ff <= master_s;
        end
    end

    // sequencers idle during master reset; master starts at release
    assign seq_rst = reset || !mr_n_s;
    assign release_pulse = mr_n_s && !mr_prev_ff && master_ff;
    assign ftok_rise = ftok_s && !ftok_prev_ff;
    assign etok_rise = etok_s && !etok_prev_ff;

    poll_ring_seq u_full_seq (
        .ref_clk(ref_clk),
        .reset(seq_rst),
        .clk_en(clk_en),
        .polled(polled_ff),
        .start(release_pulse),
        .token_rise(ftok_rise),
        .own_ff(f_own),
        .quad_ff(f_quad),
        .nxt_own(f_nxt_own),
        .nxt_quad(f_nxt_quad),
        .token_out_ff(full_token_out)
    );

    poll_ring_seq u_empty_seq (
        .ref_clk(ref_clk),
        .reset(seq_rst),
        .clk_en(clk_en),
        .polled(polled_ff),
        .start(release_pulse),
        .token_rise(etok_rise),
        .own_ff(e_own),
        .quad_ff(e_quad),
        .nxt_own(e_nxt_own),
        .nxt_quad(e_nxt_quad),
        .token_out_ff(empty_token_out)
    );

    // slices: polled buses show the quadrant entering at this edge
    assign empty_src_n = pkt_mode_ff ? queue_flags.packet_ready_n : queue_flags.almost_empty_n;
    quad_select u_full_poll (.flags_n(queue_flags.almost_full_n), .quad(f_nxt_quad), .slice_n(f_slice));
    quad_select u_empty_poll (.flags_n(empty_src_n), .quad(e_nxt_quad), .slice_n(e_poll_slice));
    quad_select u_empty_dir (.flags_n(empty_src_n), .quad(dir_quad_ff), .slice_n(e_dir_slice));
    assign small_cfg = (qcount_ff <= QCNT_DEDICATED);

    // direct mode quadrant capture; a read select in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (seq_rst) begin
            dir_quad_ff <= QUAD_FIRST;
            dir_match_ff <= 1'b0;
        end else if (clk_en && empty_quadrant_strobe && !read_queue_select && !polled_ff) begin
            dir_quad_ff <= read_queue_address[QUAD_W-1:0];
            dir_match_ff <= (read_queue_address[RADDR_W-1 -: ID_W] == id_s);
        end
    end

    // almost-full bus: polled ring or, with direct mode, floating
    always_ff @(posedge ref_clk) begin
        if (seq_rst) begin
            almost_full_status_bus <= '{data: BUS_RST, oe_n: 1'b1, sync_mark: 1'b0};
        end else if (clk_en) begin
            almost_full_status_bus.data <= f_slice;
            almost_full_status_bus.oe_n <= !(polled_ff && f_nxt_own);
            almost_full_status_bus.sync_mark <= polled_ff && f_nxt_own && (f_nxt_quad == QUAD_FIRST);
        end
    end

    // almost-empty/packet bus: fixed, polled or direct
    always_ff @(posedge ref_clk) begin
        if (seq_rst) begin
            almost_empty_packet_status_bus <= '{data: BUS_RST, oe_n: 1'b1, sync_mark: 1'b0};
        end else if (clk_en) begin
            almost_empty_packet_status_bus.sync_mark <= 1'b0;
            if (small_cfg) begin
                // queues 0 to 7 on their own lines
                almost_empty_packet_status_bus.data <= empty_src_n[BUS_W-1:0];
                almost_empty_packet_status_bus.oe_n <= 1'b0;
            end else if (polled_ff) begin
                almost_empty_packet_status_bus.data <= e_poll_slice;
                almost_empty_packet_status_bus.oe_n <= !e_nxt_own;
                almost_empty_packet_status_bus.sync_mark <= e_nxt_own && (e_nxt_quad == QUAD_FIRST);
            end else begin
                // lines of unconfigured queues pass whatever the core gives
                almost_empty_packet_status_bus.data <= e_dir_slice;
                almost_empty_packet_status_bus.oe_n <= !dir_match_ff;
            end
        end
    end

    // read queue selection; flags of a queue accessed now may lag one cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_queue_ff <= 5'h00;
        end else if (clk_en && read_queue_select) begin
            rd_queue_ff <= read_queue_address[4:0];
        end
    end

    // dedicated flags of the selected read queue
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            output_valid_n <= 1'b1;
            almost_empty_n <= 1'b1;
            packet_ready_n <= 1'b1;
        end else if (clk_en) begin
            output_valid_n <= queue_flags.output_valid_n[rd_queue_ff];
            almost_empty_n <= queue_flags.almost_empty_n[rd_queue_ff];
            packet_ready_n <= queue_flags.packet_ready_n[rd_queue_ff];
        end
    end

    // control register writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            qcount_ff <= QCNT_RST;
            pkt_mode_ff <= PKT_RST;
        end else if (clk_en && reg_write && reg_addr == CTRL_OFS) begin
            qcount_ff <= reg_wdata[CTRL_QCNT_LSB +: QCNT_W];
            pkt_mode_ff <= reg_wdata[CTRL_PKT_BIT];
        end
    end

    // register reads; unmapped offsets return zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_read && reg_addr == CTRL_OFS) begin
                reg_rdata[CTRL_QCNT_LSB +: QCNT_W] <= qcount_ff;
                reg_rdata[CTRL_PKT_BIT] <= pkt_mode_ff;
            end else if (reg_read && reg_addr == STATUS_OFS) begin
                reg_rdata[ST_POLLED_BIT] <= polled_ff;
                reg_rdata[ST_MASTER_BIT] <= master_ff;
                reg_rdata[ST_FOWN_BIT] <= f_own;
                reg_rdata[ST_EOWN_BIT] <= e_own;
                reg_rdata[ST_EQUAD_LSB +: QUAD_W] <= e_quad;
                reg_rdata[ST_FQUAD_LSB +: QUAD_W] <= f_quad;
            end
        end
    end

    // checks, all frozen with clk_en low
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (seq_rst || !clk_en);

    sequence s_full_start;
        polled_ff && release_pulse;
    endsequence
    sequence s_full_walk;
        !almost_full_status_bus.oe_n && almost_full_status_bus.sync_mark ##1
        (!almost_full_status_bus.oe_n && !almost_full_status_bus.sync_mark) [*3];
    endsequence

    a_full_master_start: assert property (s_full_start |=> s_full_walk)
        else $error("master full bus walk wrong after release");
    a_full_quad_step: assert property (polled_ff && f_own && f_quad != QUAD_LAST && !ftok_rise
        |=> f_quad == $past(f_quad) + 2'h1)
        else $error("full quadrant did not step");
    a_full_sync_first: assert property (almost_full_status_bus.sync_mark
        |-> f_own && f_quad == QUAD_FIRST)
        else $error("full sync mark off first quadrant");
    a_full_token_out: assert property (polled_ff && f_own && f_quad == QUAD_LAST
        |=> full_token_out)
        else $error("full token not passed");
    a_empty_sync_first: assert property (almost_empty_packet_status_bus.sync_mark
        |-> e_own && e_quad == QUAD_FIRST && !almost_empty_packet_status_bus.oe_n)
        else $error("empty sync mark off first quadrant");
    a_empty_token_out: assert property (polled_ff && e_own && e_quad == QUAD_LAST && !etok_rise
        |=> empty_token_out && !e_own)
        else $error("empty token not passed");
    a_direct_latency: assert property (!polled_ff && !small_cfg && empty_quadrant_strobe && !read_queue_select
        ##1 !empty_quadrant_strobe |=> almost_empty_packet_status_bus.data == $past(e_dir_slice))
        else $error("direct bus late");
    a_small_fixed: assert property (small_cfg |=> !almost_empty_packet_status_bus.oe_n
        && almost_empty_packet_status_bus.data == $past(empty_src_n[BUS_W-1:0]))
        else $error("small config bus wrong");
    a_read_flags: assert property (1'b1 |=> output_valid_n == $past(queue_flags.output_valid_n[rd_queue_ff]))
        else $error("output valid flag wrong");
    // direct mode has no almost-full sharing here, so that bus must stay released
    a_full_direct_float: assert property (!polled_ff |=> almost_full_status_bus.oe_n)
        else $error("full bus driven in direct mode");
    // in direct mode with more than eight queues, a device whose id was not addressed keeps the shared empty bus released
    a_direct_id_float: assert property (!polled_ff && !small_cfg && !dir_match_ff
        |=> almost_empty_packet_status_bus.oe_n)
        else $error("empty bus driven without id match");
endmodule
`default_nettype wire
